// >>> design/csar_pkg.sv
/*
 * csar_pkg: constants and carrier types for the core sequencing block
 * (stack pointers, operand addressing, reset sequencing, APB registers).
 * Assumes a 200 MHz pclk; all timing counts derive from it.
 */
package csar_pkg;

	localparam int CLK_MHZ = 200;
	// timing figures as printed, then cycle counts
	localparam int T_NOINT_US = 1000;
	localparam int T_WAIT_US = 95000;
	localparam int T_WATCHDOG_US = 2000;
	localparam int NOINT_CYC = T_NOINT_US * CLK_MHZ;
	localparam int WAIT_CYC = T_WAIT_US * CLK_MHZ;
	localparam int WATCHDOG_CYC = T_WATCHDOG_US * CLK_MHZ;

	// APB register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_OPND = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_RES = 8'h0c;
	localparam logic [7:0] OFS_PSCR = 8'h10;
	localparam logic [7:0] OFS_DSP = 8'h14;
	localparam logic [7:0] OFS_IDX = 8'h18;
	localparam logic [7:0] OFS_USBEN = 8'h1c;

	// status and control field positions
	localparam int PSCR_POR_BIT = 4;
	localparam int PSCR_WATCHDOG_BIT = 6;
	localparam int USBEN_BUSRST_BIT = 0;
	localparam logic [7:0] PSCR_RST = 8'h00;
	localparam logic [7:0] SP_RST = 8'h00;
	localparam logic [13:0] PC_RST = 14'h0000;

	// software commands, written to the command register
	typedef enum logic [3:0] {
		CSAR_OP_NONE,
		CSAR_OP_CALL,
		CSAR_OP_SUB_RETURN,
		CSAR_OP_INT_RETURN,
		CSAR_OP_PUSH,
		CSAR_OP_POP,
		CSAR_OP_LDPSP,
		CSAR_OP_IMM,
		CSAR_OP_DIR,
		CSAR_OP_IDX,
		CSAR_OP_INT_ENABLE,
		CSAR_OP_IRQ
	} csar_op_t;

	// saved return frame
	typedef struct packed {
		logic [13:0] pc;
		logic carry;
		logic zero;
	} csar_frame_t;

	// command word: op, operand byte, frame to push
	typedef struct packed {
		csar_op_t op;
		logic [7:0] operand;
		csar_frame_t frame;
	} csar_cmd_t;

	// increment/decrement modulo 256
	function automatic logic [7:0] csar_step(input logic [7:0] p,
		input logic up);
		csar_step = up ? 8'(p + 8'h01) : 8'(p - 8'h01);
	endfunction : csar_step

endpackage : csar_pkg

// >>> design/csar_core.sv
/*
 * csar_core: stack pointers, 256-byte data RAM, operand address modes
 * and reset/semi-suspend sequencing, with an APB slave for control.
 * Assumes APB master on pclk; por_n and watchdog_reset_event are
 * synchronous inputs, por_n low means power-on reset indication.
 */
// Design decisions made here: the APB interface to the registers and the address map.
// How it works
// - return_stack_pointer resets to 00 and grows upward.
// - pointer loadable from accumulator; never readable by firmware.
// - interrupt acknowledge disables interrupts, pushes two frame bytes.
// - interrupt return pops second then first byte, then re-enables.
// - call pushes pc and flags as two bytes, pointer plus two.
// - subroutine return restores pc only, pointer minus two.
// - push pre-decrements data pointer then writes.
// - pop reads at data pointer then post-increments.
// - data pointer resets to 00; push at 00 writes ff.
// - 256-byte data RAM addressed by pointers and operands.
// - immediate mode uses second instruction byte as value.
// - direct mode uses instruction byte as RAM address.
// - indexed mode address is byte plus index register.
// - both resets restore defaults, usb address, interrupts, pointers.
// - reset cause kept in status bit 4 power-on, bit 6 watchdog.
// - after reset execution starts at 0000 with nothing pushed.
// - semi-suspend with cpu stopped while power-on reset asserted.
// - after release, 1 ms uninterruptible then 95 ms wait.
// - usb bus reset in 95 ms wait ends it; interrupt stays pending.
// - power-on indication reasserting repeats the whole sequence.
// - watchdog reset holds 2 ms then starts at address zero.
`timescale 1ns/100ps
`default_nettype none
module csar_core
	import csar_pkg::*;
#(
	parameter int NOINT_CYCLES = NOINT_CYC,
	parameter int WAIT_CYCLES = WAIT_CYC,
	parameter int WATCHDOG_CYCLES = WATCHDOG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic por_n,
	input wire logic watchdog_reset_event,
	input wire logic usb_bus_reset,
	output logic cpu_run,
	output logic [13:0] pc,
	output logic int_enable,
	output logic [6:0] usb_dev_addr,
	output logic bus_reset_irq
);

	typedef enum {ST_POR, ST_NOINT, ST_WAIT, ST_WATCHDOG, ST_RUN} csar_st_t;

	csar_st_t state;
	logic [31:0] cnt;
	logic [7:0] ram [256];
	logic [7:0] return_stack_pointer;
	logic [7:0] dsp;
	logic [7:0] index_x;
	logic [7:0] result;
	logic [7:0] pscr;
	logic [7:0] usb_en;
	logic carry, zero;
	logic bus_reset_pending;
	logic [1:0] phase;
	csar_cmd_t cmd;
	logic busy;
	logic soft_rst;
	logic wr, start;

	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign start = wr && paddr[7:0] == OFS_CMD && !busy && cpu_run;
	assign soft_rst = state != ST_RUN;
	assign cpu_run = state == ST_RUN;

	// reset and semi-suspend sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_POR;
			cnt <= '0;
		end else if (!por_n) begin
			state <= ST_POR;
			cnt <= '0;
		end else if (watchdog_reset_event) begin
			state <= ST_WATCHDOG;
			cnt <= '0;
		end else begin
			unique case (state)
				ST_POR: begin
					state <= ST_NOINT;
					cnt <= '0;
				end
				ST_NOINT: begin
					cnt <= cnt + 32'd1;
					if (cnt >= 32'(NOINT_CYCLES - 1)) begin
						state <= ST_WAIT;
						cnt <= '0;
					end
				end
				ST_WAIT: begin
					cnt <= cnt + 32'd1;
					if (usb_bus_reset || cnt >= 32'(WAIT_CYCLES - 1))
						state <= ST_RUN;
				end
				ST_WATCHDOG: begin
					cnt <= cnt + 32'd1;
					if (cnt >= 32'(WATCHDOG_CYCLES - 1))
						state <= ST_RUN;
				end
				ST_RUN: ;
			endcase
		end
	end

	// reset cause flags; a new power-on clears the watchdog flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pscr <= PSCR_RST;
		end else if (!por_n) begin
			pscr <= PSCR_RST;
			pscr[PSCR_POR_BIT] <= 1'b1;
		end else if (watchdog_reset_event) begin
			pscr[PSCR_WATCHDOG_BIT] <= 1'b1;
		end else if (wr && paddr[7:0] == OFS_PSCR) begin
			pscr <= pwdata[7:0];
		end
	end

	// pending bus reset interrupt, held until enabled and interrupts on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bus_reset_pending <= 1'b0;
		else if (state == ST_WAIT && usb_bus_reset)
			bus_reset_pending <= 1'b1;
		else if (soft_rst)
			bus_reset_pending <= 1'b0;
		else if (cmd.op == CSAR_OP_IRQ && busy && phase == 2'd0)
			bus_reset_pending <= 1'b0;
	end
	assign bus_reset_irq = bus_reset_pending && int_enable &&
		usb_en[USBEN_BUSRST_BIT];

	// plain control registers restored by either reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_en <= '0;
			usb_dev_addr <= '0;
			index_x <= '0;
			cmd <= '0;
		end else if (soft_rst) begin
			usb_en <= '0;
			usb_dev_addr <= '0;
			index_x <= '0;
			cmd <= '0;
		end else begin
			if (wr && paddr[7:0] == OFS_USBEN) begin
				usb_en <= pwdata[7:0];
				usb_dev_addr <= pwdata[14:8];
			end
			if (wr && paddr[7:0] == OFS_IDX)
				index_x <= pwdata[7:0];
			if (start)
				cmd <= csar_cmd_t'(pwdata[27:0]);
		end
	end

	// command engine: stack sequences and operand access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			return_stack_pointer <= SP_RST;
			dsp <= SP_RST;
			busy <= 1'b0;
			phase <= '0;
			pc <= PC_RST;
			carry <= 1'b0;
			zero <= 1'b0;
			int_enable <= 1'b0;
			result <= '0;
		end else if (soft_rst) begin
			return_stack_pointer <= SP_RST;
			dsp <= SP_RST;
			busy <= 1'b0;
			phase <= '0;
			pc <= PC_RST;
			carry <= 1'b0;
			zero <= 1'b0;
			int_enable <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
			phase <= '0;
		end else if (busy) begin
			phase <= phase + 2'd1;
			unique case (cmd.op)
				CSAR_OP_CALL, CSAR_OP_IRQ: begin
					if (cmd.op == CSAR_OP_IRQ)
						int_enable <= 1'b0;
					return_stack_pointer <=
						csar_step(return_stack_pointer, 1'b1);
					if (phase == 2'd1) begin
						busy <= 1'b0;
						pc <= cmd.frame.pc;
					end
				end
				CSAR_OP_SUB_RETURN, CSAR_OP_INT_RETURN: begin
					if (phase == 2'd0 || phase == 2'd2)
						return_stack_pointer <=
							csar_step(return_stack_pointer, 1'b0);
					if (phase == 2'd1)
						pc[7:0] <= ram[return_stack_pointer];
					if (phase == 2'd3) begin
						pc[13:8] <= ram[return_stack_pointer][5:0];
						if (cmd.op == CSAR_OP_INT_RETURN) begin
							carry <= ram[return_stack_pointer][7];
							zero <= ram[return_stack_pointer][6];
							int_enable <= 1'b1;
						end
						busy <= 1'b0;
					end
				end
				CSAR_OP_PUSH: begin
					if (phase == 2'd0)
						dsp <= csar_step(dsp, 1'b0);
					else
						busy <= 1'b0;
				end
				CSAR_OP_POP: begin
					result <= ram[dsp];
					dsp <= csar_step(dsp, 1'b1);
					busy <= 1'b0;
				end
				CSAR_OP_LDPSP: begin
					return_stack_pointer <= cmd.operand;
					busy <= 1'b0;
				end
				CSAR_OP_IMM: begin
					result <= cmd.operand;
					busy <= 1'b0;
				end
				CSAR_OP_DIR: begin
					result <= ram[cmd.operand];
					busy <= 1'b0;
				end
				CSAR_OP_IDX: begin
					result <= ram[8'(cmd.operand + index_x)];
					busy <= 1'b0;
				end
				CSAR_OP_INT_ENABLE: begin
					int_enable <= 1'b1;
					busy <= 1'b0;
				end
				default: busy <= 1'b0;
			endcase
		end
	end

	// data RAM writes: frame bytes and pushed data
	always_ff @(posedge pclk) begin
		if (busy && !soft_rst) begin
			if ((cmd.op == CSAR_OP_CALL || cmd.op == CSAR_OP_IRQ) &&
				phase == 2'd0)
				ram[return_stack_pointer] <= {2'b00, cmd.frame.pc[13:8]}
					| {cmd.frame.carry, cmd.frame.zero, 6'h00};
			else if ((cmd.op == CSAR_OP_CALL || cmd.op == CSAR_OP_IRQ) &&
				phase == 2'd1)
				ram[return_stack_pointer] <= cmd.frame.pc[7:0];
			else if (cmd.op == CSAR_OP_PUSH && phase == 2'd1)
				ram[dsp] <= cmd.operand;
		end
	end

	// APB read mux; return_stack_pointer is deliberately absent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr[7:0])
				OFS_STAT: prdata <= {24'h0, 1'b0, phase, busy, cpu_run,
					carry, zero, int_enable};
				OFS_RES: prdata <= {24'h0, result};
				OFS_PSCR: prdata <= {24'h0, pscr};
				OFS_DSP: prdata <= {24'h0, dsp};
				OFS_IDX: prdata <= {24'h0, index_x};
				OFS_USBEN: prdata <= {17'h0, usb_dev_addr, usb_en};
				default: prdata <= '0;
			endcase
		end
	end
	assign pslverr = 1'b0;

	// pushes land at the pre-decremented data pointer
	push_wrap_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		busy && cmd.op == CSAR_OP_PUSH && phase == 2'd0 && !soft_rst
		|=> dsp == 8'($past(dsp) - 8'h01))
		else $error("push did not pre-decrement");
	// a pop reads first and then steps the data pointer up
	pop_step_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		busy && cmd.op == CSAR_OP_POP && !soft_rst
		|=> dsp == 8'($past(dsp) + 8'h01))
		else $error("pop did not post-increment");
	// a call accepted, then three cycles clear of reset
	sequence call_issue_s;
		start && pwdata[27:24] == 4'(CSAR_OP_CALL)
		##1 !soft_rst [*3];
	endsequence
	// call leaves the pointer two higher once both bytes are stored
	call_rise_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		call_issue_s |-> return_stack_pointer ==
		8'($past(return_stack_pointer, 3) + 8'h02))
		else $error("call did not raise pointer by two");
	// a subroutine return accepted, then four cycles clear of reset
	sequence return_issue_s;
		start && pwdata[27:24] == 4'(CSAR_OP_SUB_RETURN)
		##1 !soft_rst [*4];
	endsequence
	// return leaves the pointer two lower
	return_drop_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		return_issue_s |-> return_stack_pointer ==
		8'($past(return_stack_pointer, 4) - 8'h02))
		else $error("return did not drop pointer by two");
	// reset clears pointers and program counter
	rst_clear_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		soft_rst |=> return_stack_pointer == 8'h00 && dsp == 8'h00 &&
		pc == 14'h0000)
		else $error("reset left state behind");
	// power-on indication stops the cpu next cycle
	por_stop_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!por_n |=> !cpu_run && pscr[PSCR_POR_BIT])
		else $error("cpu ran during power-on reset");
	// interrupt acknowledge masks interrupts while it stacks the frame
	irq_mask_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		busy && cmd.op == CSAR_OP_IRQ && !soft_rst |=> !int_enable)
		else $error("interrupts left on during acknowledge");
endmodule : csar_core
`default_nettype wire

// >>> testbench/cpu_stack_addressing_reset_bench.sv
/*
 * cpu_stack_addressing_reset_bench: self-checking bench for csar_core,
 * driving APB register and command traffic plus the reset inputs.
 * Assumes csar_pkg and a zero-wait APB slave; timing counts shortened.
 */
`timescale 1ns/100ps
`default_nettype none
module cpu_stack_addressing_reset_bench import csar_pkg::*; ;
	logic pclk = 1'b0, presetn, psel, penable, pwrite, por_n;
	logic watchdog_ev, usb_rst;
	logic [31:0] paddr, pwdata, prdata, q;
	logic pready, pslverr, cpu_run, int_enable, bus_reset_irq;
	logic [13:0] pc;
	logic [6:0] usb_dev_addr;
	int n_fail = 0, cmp_count = 0, k;
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	csar_core #(.NOINT_CYCLES(10), .WAIT_CYCLES(50),
		.WATCHDOG_CYCLES(20)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .por_n(por_n),
		.watchdog_reset_event(watchdog_ev), .usb_bus_reset(usb_rst),
		.cpu_run(cpu_run), .pc(pc), .int_enable(int_enable),
		.usb_dev_addr(usb_dev_addr), .bus_reset_irq(bus_reset_irq)
	);
	task end_of_test;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task hang;
		n_fail++;
		end_of_test();
	endtask : hang
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// one APB transfer; read data lands in q
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 50) hang();
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rchk
	// issue a command and wait until busy drops
	task cmd(input csar_op_t op, input logic [7:0] v, input logic [15:0] f);
		csar_cmd_t c;
		c.op = op;
		c.operand = v;
		c.frame = f;
		apb(1'b1, OFS_CMD, {4'h0, c});
		repeat (2) @(posedge pclk);
		k = 0;
		do begin
			apb(1'b0, OFS_STAT, 32'h0);
			k++;
			if (k > 40) hang();
		end while (q[4] !== 1'b0);
	endtask : cmd
	// count cycles until the cpu runs, bounded by hi
	task run_wait(input int lo, input int hi);
		int n;
		n = 0;
		while (cpu_run !== 1'b1) begin
			@(posedge pclk);
			n++;
			if (n > hi) hang();
		end
		chk({31'h0, n >= lo}, 32'h1);
	endtask : run_wait
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, por_n, watchdog_ev, usb_rst} = 7'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// power-on indication outlasts the bus reset, so the cause is seen
		repeat (2) @(posedge pclk);
		por_n <= 1'b1;
		run_wait(60, 70);
		chk({18'h0, pc}, 32'h0);
		chk({24'h0, int_enable, usb_dev_addr}, 32'h0);
		rchk(OFS_PSCR, 32'h10, 32'h10);
		rchk(OFS_DSP, 32'hff, 32'h00);
		cmd(CSAR_OP_PUSH, 8'h5a, 16'h0);
		rchk(OFS_DSP, 32'hff, 32'hff);
		cmd(CSAR_OP_DIR, 8'hff, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h5a);
		cmd(CSAR_OP_POP, 8'h00, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h5a);
		rchk(OFS_DSP, 32'hff, 32'h00);
		cmd(CSAR_OP_IMM, 8'h3c, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h3c);
		apb(1'b1, OFS_IDX, 32'hfe);
		cmd(CSAR_OP_IDX, 8'h01, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h5a);
		// return frame stored upward from zero
		cmd(CSAR_OP_CALL, 8'h00, {14'h1234, 2'b10});
		cmd(CSAR_OP_DIR, 8'h00, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h92);
		cmd(CSAR_OP_DIR, 8'h01, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h34);
		// move pc away, then point back at the first frame
		cmd(CSAR_OP_CALL, 8'h00, {14'h0abc, 2'b01});
		cmd(CSAR_OP_LDPSP, 8'h02, 16'h0);
		cmd(CSAR_OP_SUB_RETURN, 8'h00, 16'h0);
		chk({18'h0, pc}, 32'h1234);
		rchk(OFS_STAT, 32'h6, 32'h0);
		cmd(CSAR_OP_INT_ENABLE, 8'h00, 16'h0);
		cmd(CSAR_OP_IRQ, 8'h00, {14'h0abc, 2'b01});
		chk({31'h0, int_enable}, 32'h0);
		cmd(CSAR_OP_DIR, 8'h00, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h4a);
		cmd(CSAR_OP_DIR, 8'h01, 16'h0);
		rchk(OFS_RES, 32'hff, 32'hbc);
		cmd(CSAR_OP_CALL, 8'h00, {14'h1234, 2'b10});
		cmd(CSAR_OP_LDPSP, 8'h02, 16'h0);
		cmd(CSAR_OP_INT_RETURN, 8'h00, 16'h0);
		chk({17'h0, int_enable, pc}, 32'h4abc);
		rchk(OFS_STAT, 32'h6, 32'h2);
		cmd(CSAR_OP_LDPSP, 8'h40, 16'h0);
		cmd(CSAR_OP_CALL, 8'h00, {14'h1234, 2'b10});
		cmd(CSAR_OP_DIR, 8'h40, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h92);
		rchk(8'h40, 32'hffffffff, 32'h0);
		chk({31'h0, pslverr}, 32'h0);
		apb(1'b1, OFS_USBEN, 32'h2a00);
		rchk(OFS_USBEN, 32'h7f00, 32'h2a00);
		// watchdog reset
		@(posedge pclk);
		watchdog_ev <= 1'b1;
		@(posedge pclk);
		watchdog_ev <= 1'b0;
		@(posedge pclk);
		chk({31'h0, cpu_run}, 32'h0);
		run_wait(18, 30);
		chk({17'h0, int_enable, pc}, 32'h0);
		chk({25'h0, usb_dev_addr}, 32'h0);
		rchk(OFS_PSCR, 32'h40, 32'h40);
		rchk(OFS_DSP, 32'hff, 32'h00);
		cmd(CSAR_OP_CALL, 8'h00, {14'h1234, 2'b10});
		cmd(CSAR_OP_DIR, 8'h00, 16'h0);
		rchk(OFS_RES, 32'hff, 32'h92);
		// power-on again, cut short by a bus reset
		por_n <= 1'b0;
		repeat (4) @(posedge pclk);
		por_n <= 1'b1;
		repeat (5) @(posedge pclk);
		usb_rst <= 1'b1;
		run_wait(7, 12);
		usb_rst <= 1'b0;
		rchk(OFS_PSCR, 32'h50, 32'h10);
		chk({31'h0, bus_reset_irq}, 32'h0);
		apb(1'b1, OFS_USBEN, 32'h1);
		chk({31'h0, bus_reset_irq}, 32'h0);
		cmd(CSAR_OP_INT_ENABLE, 8'h00, 16'h0);
		chk({31'h0, bus_reset_irq}, 32'h1);
		end_of_test();
	end
endmodule : cpu_stack_addressing_reset_bench
`default_nettype wire
